/* shared/tmcc_pkg.sv */
// Constants for the 16-bit timer mode, clock and capture control block.
// Assumes an 8-bit I/O register port from the CPU core at the I/O clock.
package tmcc_pkg;
	// I/O register indices on the 4-bit I/O address
	localparam logic [3:0] ADDR_CTRL_A = 4'h0;
	localparam logic [3:0] ADDR_CTRL_B = 4'h1;
	localparam logic [3:0] ADDR_CNT_L = 4'h2;
	localparam logic [3:0] ADDR_CNT_H = 4'h3;
	localparam logic [3:0] ADDR_CMPA_L = 4'h4;
	localparam logic [3:0] ADDR_CMPA_H = 4'h5;
	localparam logic [3:0] ADDR_CMPB_L = 4'h6;
	localparam logic [3:0] ADDR_CMPB_H = 4'h7;
	localparam logic [3:0] ADDR_CAP_L = 4'h8;
	localparam logic [3:0] ADDR_CAP_H = 4'h9;
	localparam logic [3:0] ADDR_FLAGS = 4'hA;
	localparam logic [3:0] ADDR_MASK = 4'hB;
	// Control B field positions
	localparam int CTRLB_FILT_BIT = 7;
	localparam int CTRLB_EDGE_BIT = 6;
	localparam int CTRLB_MODE_HI = 4;
	localparam int CTRLB_MODE_LO = 3;
	// Control A writable bits (force strobes and bits 3:2 read zero)
	localparam logic [7:0] CTRLA_RW_MASK = 8'hF3;
	localparam logic [7:0] CTRLB_RW_MASK = 8'hDF;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// Flag and mask bit positions
	localparam int FLAG_OVF = 0;
	localparam int FLAG_CMPB = 1;
	localparam int FLAG_CMPA = 2;
	localparam int FLAG_CAP = 3;
	// Waveform modes
	localparam logic [3:0] MODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_CLR_CMPA = 4'h4;
	localparam logic [3:0] MODE_PFC_CAP = 4'h8;
	localparam logic [3:0] MODE_PFC_CMPA = 4'h9;
	localparam logic [3:0] MODE_PC_CAP = 4'hA;
	localparam logic [3:0] MODE_PC_CMPA = 4'hB;
	localparam logic [3:0] MODE_CLR_CAP = 4'hC;
	localparam logic [3:0] MODE_RESERVED = 4'hD;
	localparam logic [3:0] MODE_FAST_CAP = 4'hE;
	localparam logic [3:0] MODE_FAST_CMPA = 4'hF;
	// Fixed top values
	localparam logic [15:0] TOP_8BIT = 16'h00FF;
	localparam logic [15:0] TOP_9BIT = 16'h01FF;
	localparam logic [15:0] TOP_10BIT = 16'h03FF;
	localparam logic [15:0] TOP_MAX = 16'hFFFF;
	localparam logic [15:0] BOTTOM = 16'h0000;
	// Clock select codes
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	// Prescaler terminal counts for the divided ticks
	localparam logic [9:0] PRE_END8 = 10'h007;
	localparam logic [9:0] PRE_END64 = 10'h03F;
	localparam logic [9:0] PRE_END256 = 10'h0FF;
	localparam logic [9:0] PRE_END1024 = 10'h3FF;
	// Noise filter depth in samples
	localparam int FILT_DEPTH = 4;
	// Compare register update points and overflow flag points
	typedef enum logic [1:0] {EV_IMM = 2'h0, EV_TOP = 2'h1, EV_BOT = 2'h3, EV_MAX = 2'h2} tmcc_ev_t;
endpackage : tmcc_pkg

/* verilog/tmcc_capture_filter.sv */
// Capture input noise filter: output follows the input after four equal samples.
// Assumes its input is already synchronised to clk.
`timescale 1ns/1ps
module tmcc_capture_filter (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic filt_en,
	input wire logic pin_sync,
	output logic pin_filt
);
	// Last samples of the synchronised pin
	logic [tmcc_pkg::FILT_DEPTH-1:0] hist_q;
	// Filtered level
	logic filt_q;

	// Shift in one sample per clock
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hist_q <= '0;
		end else begin
			hist_q <= {hist_q[tmcc_pkg::FILT_DEPTH-2:0], pin_sync};
		end
	end

	// Change only when all samples agree; bypass when disabled
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			filt_q <= 1'b0;
		end else if (!filt_en) begin
			filt_q <= pin_sync;
		end else if (&hist_q) begin
			filt_q <= 1'b1;
		end else if (~|hist_q) begin
			filt_q <= 1'b0;
		end
	end

	assign pin_filt = filt_q;

	filter_four_equal_a: assert property (@(posedge clk) disable iff (sys_rst)
		(filt_en && $past(filt_en) && $changed(filt_q)) |->
		($past(hist_q) == {tmcc_pkg::FILT_DEPTH{filt_q}}))
		else $error("filter output changed without four equal samples");
endmodule : tmcc_capture_filter

/* verilog/tmcc_timer16.sv */
// 16-bit timer with waveform modes, clock selection, capture and byte access.
// Assumes an 8-bit I/O port from the CPU on clk; pins are asynchronous.
//
// How it works
// - Mode is two bits A plus two bits B
// - Phase correct: fixed tops, update top, flag bottom
// - Fast PWM: fixed tops, update bottom, flag top
// - Phase-frequency correct: update and flag at bottom
// - Normal and clear-on-match: immediate update, flag MAX
// - Filter needs four equal capture samples
// - Edge select: zero falling, one rising
// - Capture copies counter and sets flag
// - Capture disabled when capture register is top
// - Code zero stops; codes divide I/O clock
// - Codes six, seven count external pin edges
// - External pin counts even as output
// - Counter readable and writable by two bytes
// - One shared temporary high byte register
// - Counter write blocks next compare match
// - Capture-top modes flag capture at top
// - Capture flag cleared by vector or one
`timescale 1ns/1ps
module tmcc_timer16 (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [3:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	input wire logic capture_pin,
	input wire logic ext_count_pin,
	input wire logic [3:0] vec_ack,
	output logic [3:0] irq
);
	// Control registers
	logic [7:0] counter_control_a_q;
	logic [7:0] counter_control_b_q;
	// Counter, direction and compare blocking
	logic [15:0] counter_value_q;
	logic count_up_q;
	logic cmp_block_q;
	// Compare registers: active and buffered
	logic [15:0] compare_reg_a_q;
	logic [15:0] compare_reg_b_q;
	logic [15:0] cmpa_buf_q;
	logic [15:0] cmpb_buf_q;
	// Capture register and the shared temporary high byte
	logic [15:0] capture_reg_q;
	logic [7:0] temp_q;
	// Flags, mask, interrupt lines and read data
	logic [3:0] flags_q;
	logic [3:0] mask_q;
	logic [3:0] irq_q;
	logic [7:0] rdata_q;
	// Prescaler and pin synchronisers
	logic [9:0] presc_q;
	logic [1:0] ext_sync_q;
	logic ext_prev_q;
	logic [1:0] cap_sync_q;
	logic cap_prev_q;
	logic cap_filt;

	// Decoded controls
	logic [3:0] waveform_mode_sel;
	logic [2:0] clock_source_sel;
	logic capture_edge_sel;
	logic capture_noise_filter_en;
	logic [15:0] top_val;
	logic dual_slope;
	logic cap_is_top;
	logic tick;
	logic at_top;
	logic at_bot;
	logic at_max;
	logic cap_evt;
	logic cnt_wr;
	logic upd_evt;
	logic ovf_evt;
	logic [3:0] flag_set;
	logic [3:0] flag_clr;
	tmcc_pkg::tmcc_ev_t upd_pt;
	tmcc_pkg::tmcc_ev_t ovf_pt;

	// Top value for a mode
	function automatic logic [15:0] mode_top(input logic [3:0] m, input logic [15:0] ca,
		input logic [15:0] cp);
		case (m[1:0])
			2'h1: mode_top = tmcc_pkg::TOP_8BIT;
			2'h2: mode_top = tmcc_pkg::TOP_9BIT;
			default: mode_top = tmcc_pkg::TOP_10BIT;
		endcase
		case (m)
			tmcc_pkg::MODE_NORMAL, tmcc_pkg::MODE_RESERVED: mode_top = tmcc_pkg::TOP_MAX;
			tmcc_pkg::MODE_CLR_CMPA, tmcc_pkg::MODE_PFC_CMPA, tmcc_pkg::MODE_PC_CMPA,
			tmcc_pkg::MODE_FAST_CMPA: mode_top = ca;
			tmcc_pkg::MODE_PFC_CAP, tmcc_pkg::MODE_PC_CAP, tmcc_pkg::MODE_CLR_CAP,
			tmcc_pkg::MODE_FAST_CAP: mode_top = cp;
			default: mode_top = mode_top;
		endcase
	endfunction : mode_top

	// True when the capture register sets the top
	function automatic logic mode_cap_top(input logic [3:0] m);
		mode_cap_top = (m == tmcc_pkg::MODE_PFC_CAP) || (m == tmcc_pkg::MODE_PC_CAP) ||
			(m == tmcc_pkg::MODE_CLR_CAP) || (m == tmcc_pkg::MODE_FAST_CAP);
	endfunction : mode_cap_top

	// Point at which the compare registers take their buffered value
	function automatic tmcc_pkg::tmcc_ev_t mode_upd(input logic [3:0] m);
		case (m)
			4'h1, 4'h2, 4'h3, 4'hA, 4'hB: mode_upd = tmcc_pkg::EV_TOP;
			4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hE, 4'hF: mode_upd = tmcc_pkg::EV_BOT;
			default: mode_upd = tmcc_pkg::EV_IMM;
		endcase
	endfunction : mode_upd

	// Point at which the overflow flag sets
	function automatic tmcc_pkg::tmcc_ev_t mode_ovf(input logic [3:0] m);
		case (m)
			4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: mode_ovf = tmcc_pkg::EV_BOT;
			4'h5, 4'h6, 4'h7, 4'hE, 4'hF: mode_ovf = tmcc_pkg::EV_TOP;
			default: mode_ovf = tmcc_pkg::EV_MAX;
		endcase
	endfunction : mode_ovf

	// Mode from two control A bits and two control B bits
	assign waveform_mode_sel = {counter_control_b_q[tmcc_pkg::CTRLB_MODE_HI:
		tmcc_pkg::CTRLB_MODE_LO], counter_control_a_q[1:0]};
	assign clock_source_sel = counter_control_b_q[2:0];
	assign capture_edge_sel = counter_control_b_q[tmcc_pkg::CTRLB_EDGE_BIT];
	assign capture_noise_filter_en = counter_control_b_q[tmcc_pkg::CTRLB_FILT_BIT];
	assign top_val = mode_top(waveform_mode_sel, compare_reg_a_q, capture_reg_q);
	assign dual_slope = (mode_upd(waveform_mode_sel) == tmcc_pkg::EV_TOP) ||
		(waveform_mode_sel == tmcc_pkg::MODE_PFC_CAP) ||
		(waveform_mode_sel == tmcc_pkg::MODE_PFC_CMPA);
	assign cap_is_top = mode_cap_top(waveform_mode_sel);
	assign upd_pt = mode_upd(waveform_mode_sel);
	assign ovf_pt = mode_ovf(waveform_mode_sel);

	// Timer clock: prescaled I/O clock or an edge of the external pin
	always_comb begin
		case (clock_source_sel)
			tmcc_pkg::CS_STOP: tick = 1'b0;
			tmcc_pkg::CS_DIV1: tick = 1'b1;
			tmcc_pkg::CS_DIV8: tick = (presc_q[2:0] == tmcc_pkg::PRE_END8[2:0]);
			tmcc_pkg::CS_DIV64: tick = (presc_q[5:0] == tmcc_pkg::PRE_END64[5:0]);
			tmcc_pkg::CS_DIV256: tick = (presc_q[7:0] == tmcc_pkg::PRE_END256[7:0]);
			tmcc_pkg::CS_DIV1024: tick = (presc_q == tmcc_pkg::PRE_END1024);
			tmcc_pkg::CS_EXT_FALL: tick = ext_prev_q && !ext_sync_q[1];
			tmcc_pkg::CS_EXT_RISE: tick = !ext_prev_q && ext_sync_q[1];
			default: tick = 1'b0;
		endcase
	end

	// Counter positions in the sequence, meaningful on a timer tick
	assign at_top = tick && (counter_value_q == top_val);
	assign at_max = tick && (counter_value_q == tmcc_pkg::TOP_MAX);
	assign at_bot = tick && (counter_value_q == tmcc_pkg::BOTTOM) && (!dual_slope || !count_up_q);
	assign cnt_wr = io_wr && ((io_addr == tmcc_pkg::ADDR_CNT_L));

	// Update and overflow events for the active mode
	assign upd_evt = ((upd_pt == tmcc_pkg::EV_TOP) && at_top) ||
		((upd_pt == tmcc_pkg::EV_BOT) && at_bot);
	assign ovf_evt = ((ovf_pt == tmcc_pkg::EV_TOP) && at_top) ||
		((ovf_pt == tmcc_pkg::EV_BOT) && at_bot) ||
		((ovf_pt == tmcc_pkg::EV_MAX) && at_max);

	// Capture edge on the chosen input, off when the capture register is top
	assign cap_evt = !cap_is_top && (capture_edge_sel ? (!cap_prev_q && cap_filt) :
		(cap_prev_q && !cap_filt));

	// Free-running prescaler, cleared to zero while the timer is stopped
	always_ff @(posedge clk) begin
		if (sys_rst || clock_source_sel == tmcc_pkg::CS_STOP) begin
			presc_q <= '0;
		end else begin
			presc_q <= presc_q + 10'h001;
		end
	end

	// Two-stage synchronisers and edge history for both pins
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ext_sync_q <= 2'h0;
			ext_prev_q <= 1'b0;
			cap_sync_q <= 2'h0;
			cap_prev_q <= 1'b0;
		end else begin
			ext_sync_q <= {ext_sync_q[0], ext_count_pin};
			ext_prev_q <= ext_sync_q[1];
			cap_sync_q <= {cap_sync_q[0], capture_pin};
			cap_prev_q <= cap_filt;
		end
	end

	// Optional four-sample noise filter on the capture input
	tmcc_capture_filter u_filter (
		.clk(clk),
		.sys_rst(sys_rst),
		.filt_en(capture_noise_filter_en),
		.pin_sync(cap_sync_q[1]),
		.pin_filt(cap_filt)
	);

	// Control registers; reserved and strobe bits are not stored
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			counter_control_a_q <= tmcc_pkg::CTRL_RESET;
			counter_control_b_q <= tmcc_pkg::CTRL_RESET;
		end else if (io_wr && io_addr == tmcc_pkg::ADDR_CTRL_A) begin
			counter_control_a_q <= io_wdata & tmcc_pkg::CTRLA_RW_MASK;
		end else if (io_wr && io_addr == tmcc_pkg::ADDR_CTRL_B) begin
			counter_control_b_q <= io_wdata & tmcc_pkg::CTRLB_RW_MASK;
		end
	end

	// Counter: writes through the temporary byte, else steps on each tick
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			counter_value_q <= tmcc_pkg::BOTTOM;
			count_up_q <= 1'b1;
		end else if (cnt_wr) begin
			counter_value_q <= {temp_q, io_wdata};
		end else if (tick && dual_slope) begin
			if (count_up_q) begin
				if (counter_value_q >= top_val) begin
					count_up_q <= 1'b0;
					counter_value_q <= counter_value_q - 16'h0001;
				end else begin
					counter_value_q <= counter_value_q + 16'h0001;
				end
			end else if (counter_value_q == tmcc_pkg::BOTTOM) begin
				count_up_q <= 1'b1;
				counter_value_q <= counter_value_q + 16'h0001;
			end else begin
				counter_value_q <= counter_value_q - 16'h0001;
			end
		end else if (tick) begin
			count_up_q <= 1'b1;
			counter_value_q <= (counter_value_q >= top_val) ? tmcc_pkg::BOTTOM :
				counter_value_q + 16'h0001;
		end
	end

	// Compare block holds from a counter write to the next timer tick
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cmp_block_q <= 1'b0;
		end else if (cnt_wr) begin
			cmp_block_q <= 1'b1;
		end else if (tick) begin
			cmp_block_q <= 1'b0;
		end
	end

	// Compare registers: buffer writes, copy at the mode's update point
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cmpa_buf_q <= '0;
			cmpb_buf_q <= '0;
			compare_reg_a_q <= '0;
			compare_reg_b_q <= '0;
		end else begin
			if (io_wr && io_addr == tmcc_pkg::ADDR_CMPA_L) begin
				cmpa_buf_q <= {temp_q, io_wdata};
			end
			if (io_wr && io_addr == tmcc_pkg::ADDR_CMPB_L) begin
				cmpb_buf_q <= {temp_q, io_wdata};
			end
			if (upd_pt == tmcc_pkg::EV_IMM) begin
				compare_reg_a_q <= cmpa_buf_q;
				compare_reg_b_q <= cmpb_buf_q;
			end else if (upd_evt) begin
				compare_reg_a_q <= cmpa_buf_q;
				compare_reg_b_q <= cmpb_buf_q;
			end
		end
	end

	// Capture register: counter copy on capture, or a byte-pair write
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			capture_reg_q <= '0;
		end else if (cap_evt) begin
			capture_reg_q <= counter_value_q;
		end else if (io_wr && io_addr == tmcc_pkg::ADDR_CAP_L) begin
			capture_reg_q <= {temp_q, io_wdata};
		end
	end

	// Shared temporary byte: filled by high writes and by low reads
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			temp_q <= 8'h00;
		end else if (io_wr && (io_addr == tmcc_pkg::ADDR_CNT_H ||
			io_addr == tmcc_pkg::ADDR_CMPA_H || io_addr == tmcc_pkg::ADDR_CMPB_H ||
			io_addr == tmcc_pkg::ADDR_CAP_H)) begin
			temp_q <= io_wdata;
		end else if (io_rd && io_addr == tmcc_pkg::ADDR_CNT_L) begin
			temp_q <= counter_value_q[15:8];
		end else if (io_rd && io_addr == tmcc_pkg::ADDR_CMPA_L) begin
			temp_q <= cmpa_buf_q[15:8];
		end else if (io_rd && io_addr == tmcc_pkg::ADDR_CMPB_L) begin
			temp_q <= cmpb_buf_q[15:8];
		end else if (io_rd && io_addr == tmcc_pkg::ADDR_CAP_L) begin
			temp_q <= capture_reg_q[15:8];
		end
	end

	// Flag events and clears
	assign flag_set[tmcc_pkg::FLAG_OVF] = ovf_evt;
	assign flag_set[tmcc_pkg::FLAG_CMPA] = tick && !cmp_block_q &&
		(counter_value_q == compare_reg_a_q);
	assign flag_set[tmcc_pkg::FLAG_CMPB] = tick && !cmp_block_q &&
		(counter_value_q == compare_reg_b_q);
	assign flag_set[tmcc_pkg::FLAG_CAP] = cap_evt || (cap_is_top && at_top);
	assign flag_clr = vec_ack | ((io_wr && io_addr == tmcc_pkg::ADDR_FLAGS) ?
		io_wdata[3:0] : 4'h0);

	// Sticky flags; a set in the clearing cycle wins
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			flags_q <= 4'h0;
		end else begin
			flags_q <= (flags_q & ~flag_clr) | flag_set;
		end
	end

	// Interrupt enables and registered interrupt lines
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mask_q <= 4'h0;
			irq_q <= 4'h0;
		end else begin
			if (io_wr && io_addr == tmcc_pkg::ADDR_MASK) begin
				mask_q <= io_wdata[3:0];
			end
			irq_q <= flags_q & mask_q;
		end
	end

	// Read data, one cycle after the read strobe
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_q <= 8'h00;
		end else if (io_rd) begin
			case (io_addr)
				tmcc_pkg::ADDR_CTRL_A: rdata_q <= counter_control_a_q;
				tmcc_pkg::ADDR_CTRL_B: rdata_q <= counter_control_b_q;
				tmcc_pkg::ADDR_CNT_L: rdata_q <= counter_value_q[7:0];
				tmcc_pkg::ADDR_CMPA_L: rdata_q <= cmpa_buf_q[7:0];
				tmcc_pkg::ADDR_CMPB_L: rdata_q <= cmpb_buf_q[7:0];
				tmcc_pkg::ADDR_CAP_L: rdata_q <= capture_reg_q[7:0];
				tmcc_pkg::ADDR_CNT_H, tmcc_pkg::ADDR_CMPA_H, tmcc_pkg::ADDR_CMPB_H,
				tmcc_pkg::ADDR_CAP_H: rdata_q <= temp_q;
				tmcc_pkg::ADDR_FLAGS: rdata_q <= {4'h0, flags_q};
				tmcc_pkg::ADDR_MASK: rdata_q <= {4'h0, mask_q};
				default: rdata_q <= 8'h00;
			endcase
		end
	end

	assign io_rdata = rdata_q;
	assign irq = irq_q;

	stop_holds_count_a: assert property (@(posedge clk) disable iff (sys_rst)
		(clock_source_sel == tmcc_pkg::CS_STOP && !cnt_wr) |=> $stable(counter_value_q))
		else $error("counter moved while stopped");
	normal_ovf_max_a: assert property (@(posedge clk) disable iff (sys_rst)
		(waveform_mode_sel == tmcc_pkg::MODE_NORMAL && at_max) |=>
		(flags_q[tmcc_pkg::FLAG_OVF] && counter_value_q == tmcc_pkg::BOTTOM))
		else $error("normal mode overflow not flagged at max");
	fast_ovf_top_a: assert property (@(posedge clk) disable iff (sys_rst)
		(waveform_mode_sel == 4'h5 && ovf_evt) |-> (counter_value_q == tmcc_pkg::TOP_8BIT))
		else $error("fast 8-bit overflow away from top");
	capture_copy_a: assert property (@(posedge clk) disable iff (sys_rst)
		cap_evt |=> (capture_reg_q == $past(counter_value_q) && flags_q[tmcc_pkg::FLAG_CAP]))
		else $error("capture did not copy counter");
	capture_top_off_a: assert property (@(posedge clk) disable iff (sys_rst)
		cap_is_top |-> !cap_evt)
		else $error("capture fired while capture register is top");
	counter_pair_a: assert property (@(posedge clk) disable iff (sys_rst)
		(io_wr && io_addr == tmcc_pkg::ADDR_CNT_H) ##1 cnt_wr |=>
		(counter_value_q == {$past(io_wdata, 2), $past(io_wdata)}))
		else $error("counter byte pair not atomic");
	write_blocks_cmp_a: assert property (@(posedge clk) disable iff (sys_rst)
		(cmp_block_q && tick) |=>
		(!$rose(flags_q[tmcc_pkg::FLAG_CMPA]) && !$rose(flags_q[tmcc_pkg::FLAG_CMPB])))
		else $error("compare match after counter write");
	flag_set_wins_a: assert property (@(posedge clk) disable iff (sys_rst)
		(flag_set[tmcc_pkg::FLAG_CAP] && flag_clr[tmcc_pkg::FLAG_CAP]) |=>
		flags_q[tmcc_pkg::FLAG_CAP])
		else $error("capture flag lost on clear");
	high_read_temp_a: assert property (@(posedge clk) disable iff (sys_rst)
		(io_rd && io_addr == tmcc_pkg::ADDR_CNT_L) ##1 (io_rd && io_addr == tmcc_pkg::ADDR_CNT_H
		&& !io_wr) |=> (io_rdata == $past(counter_value_q[15:8], 2)))
		else $error("high byte read did not return latched byte");

	capture_seen_c: cover property (@(posedge clk) disable iff (sys_rst) cap_evt);
	dual_turn_c: cover property (@(posedge clk) disable iff (sys_rst) dual_slope && at_bot);
	ext_tick_c: cover property (@(posedge clk) disable iff (sys_rst)
		clock_source_sel == tmcc_pkg::CS_EXT_RISE && tick);
	block_hit_c: cover property (@(posedge clk) disable iff (sys_rst) cmp_block_q && tick);
endmodule : tmcc_timer16

/* tb/tmcc_pin_model.sv */
// Pin-side model: drives the capture pin and the external count pin.
// Assumes the bench calls its tasks just after a rising edge of clk.
`timescale 1ns/1ps
module tmcc_pin_model (
	input wire logic clk,
	output logic capture_pin,
	output logic ext_count_pin
);
	// Both pins idle low
	initial begin
		capture_pin = 1'b0;
		ext_count_pin = 1'b0;
	end
	// Put a level on the capture pin and hold it for n clocks
	task automatic cap_level(input logic v, input int n);
		#2 capture_pin = v;
		repeat (n) @(posedge clk);
	endtask : cap_level
	// Full pulses, four clocks high and four low, slow enough for the synchroniser
	task automatic pulses(input int n);
		repeat (n) begin
			repeat (4) @(posedge clk);
			#2 ext_count_pin = 1'b1;
			repeat (4) @(posedge clk);
			#2 ext_count_pin = 1'b0;
		end
	endtask : pulses
endmodule : tmcc_pin_model

/* tb/testbench.sv */
// Self-checking bench: reset values, byte access, clocking, capture and modes.
// Assumes the design package, the timer and the pin model are compiled first.
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] io_addr = 4'h0;
	logic io_wr = 1'b0;
	logic io_rd = 1'b0;
	logic [7:0] io_wdata = 8'h00;
	logic [7:0] io_rdata;
	logic capture_pin;
	logic ext_count_pin;
	logic [3:0] vec_ack = 4'h0;
	logic [3:0] irq;
	int n_mismatch = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [31:0] lfsr_q = 32'h0000226E; // Random source, fixed start
	logic [15:0] val;
	logic [15:0] cap_v;
	logic [7:0] b8;
	// Mode table: control A, control B mode bits, start, expected count, overflow
	logic [7:0] ma [3] = '{8'h00, 8'h01, 8'h01};
	logic [7:0] mb [3] = '{8'h00, 8'h08, 8'h00};
	logic [15:0] st [3] = '{16'hFFFD, 16'h00FD, 16'h00FD};
	logic [15:0] ex [3] = '{16'h0005, 16'h0005, 16'h00F9};
	logic [15:0] fl [3] = '{16'h0001, 16'h0001, 16'h0000};
	always #12.5 clk = ~clk;
	tmcc_timer16 dut (.clk(clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .capture_pin(capture_pin),
		.ext_count_pin(ext_count_pin), .vec_ack(vec_ack), .irq(irq));
	tmcc_pin_model pins (.clk(clk), .capture_pin(capture_pin), .ext_count_pin(ext_count_pin));
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	// Ticks expected from n clocks at a clock select code
	function automatic logic [15:0] exp_ticks(input logic [2:0] cs, input int n);
		case (cs)
			tmcc_pkg::CS_DIV1: return 16'(n);
			tmcc_pkg::CS_DIV8: return 16'(n / 8);
			tmcc_pkg::CS_DIV64: return 16'(n / 64);
			tmcc_pkg::CS_DIV256: return 16'(n / 256);
			tmcc_pkg::CS_DIV1024: return 16'(n / 1024);
			default: return 16'h0000;
		endcase
	endfunction : exp_ticks
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// One write, taken at the next edge, then an idle clock
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(posedge clk);
		#2 io_wr = 1'b0;
		@(posedge clk);
		#2;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		io_addr = a;
		io_rd = 1'b1;
		@(posedge clk);
		#2 io_rd = 1'b0;
		d = io_rdata;
		@(posedge clk);
		#2;
	endtask : rd
	// High byte first on write, low byte first on read, both halves back to back
	task automatic wr16(input logic [3:0] a, input logic [15:0] v);
		io_addr = a + 4'h1;
		io_wdata = v[15:8];
		io_wr = 1'b1;
		@(posedge clk);
		#2 io_addr = a;
		io_wdata = v[7:0];
		@(posedge clk);
		#2 io_wr = 1'b0;
		@(posedge clk);
		#2;
	endtask : wr16
	task automatic rd16(input logic [3:0] a, output logic [15:0] v);
		io_addr = a;
		io_rd = 1'b1;
		@(posedge clk);
		#2 v[7:0] = io_rdata;
		io_addr = a + 4'h1;
		@(posedge clk);
		#2 io_rd = 1'b0;
		v[15:8] = io_rdata;
		@(posedge clk);
		#2;
	endtask : rd16
	// Run the counter for exactly n clocks, between a control B write that starts it and one that stops it
	task automatic run(input logic [7:0] go, input logic [7:0] stop, input int n);
		wr(tmcc_pkg::ADDR_CTRL_B, go);
		repeat (n - 2) @(posedge clk);
		#2;
		wr(tmcc_pkg::ADDR_CTRL_B, stop);
	endtask : run
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim
	// Cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		#2 sys_rst = 1'b0;
		@(posedge clk);
		#2;
		// All registers and an unmapped index read zero
		for (int a = 0; a < 13; a++) begin
			rd(4'(a), b8);
			chk("reset read", {8'h00, b8}, 16'h0000);
		end
		$display("test reset done");
		// Random counter values through the byte pair, counter stopped
		for (int i = 0; i < 4; i++) begin
			lfsr_q = lfsr_next(lfsr_q);
			wr16(tmcc_pkg::ADDR_CNT_L, lfsr_q[15:0]);
			rd16(tmcc_pkg::ADDR_CNT_L, val);
			chk("counter", val, lfsr_q[15:0]);
		end
		// High byte staged through compare A lands in the counter
		wr(tmcc_pkg::ADDR_CMPA_H, 8'hA5);
		wr(tmcc_pkg::ADDR_CNT_L, 8'h3C);
		rd16(tmcc_pkg::ADDR_CNT_L, val);
		chk("shared temp", val, 16'hA53C);
		$display("test access done");
		// Every internal clock select code for 1024 clocks
		for (int c = 0; c < 6; c++) begin
			wr16(tmcc_pkg::ADDR_CNT_L, 16'h0000);
			run(8'(c), 8'h00, 1024);
			rd16(tmcc_pkg::ADDR_CNT_L, val);
			chk("prescaled count", val, exp_ticks(3'(c), 1024));
		end
		// Each run began at a matching count right after a counter write
		rd(tmcc_pkg::ADDR_FLAGS, b8);
		chk("compare blocked", {8'h00, b8}, 16'h0000);
		$display("test prescaler done");
		// External pin, falling then rising edges
		for (int e = 6; e < 8; e++) begin
			wr16(tmcc_pkg::ADDR_CNT_L, 16'h0000);
			wr(tmcc_pkg::ADDR_CTRL_B, 8'(e));
			pins.pulses(5);
			repeat (6) @(posedge clk);
			#2;
			wr(tmcc_pkg::ADDR_CTRL_B, 8'h00);
			rd16(tmcc_pkg::ADDR_CNT_L, val);
			chk("external count", val, 16'h0005);
		end
		$display("test external clock done");
		// Rising edge capture, flag cleared by writing one
		wr(tmcc_pkg::ADDR_CTRL_B, 8'h40);
		lfsr_q = lfsr_next(lfsr_q);
		cap_v = lfsr_q[15:0];
		wr16(tmcc_pkg::ADDR_CNT_L, cap_v);
		pins.cap_level(1'b1, 10);
		rd16(tmcc_pkg::ADDR_CAP_L, val);
		chk("capture rising", val, cap_v);
		rd(tmcc_pkg::ADDR_FLAGS, b8);
		chk("capture flag", {8'h00, b8}, 16'h0008);
		wr(tmcc_pkg::ADDR_MASK, 8'h08);
		chk("capture irq", {12'h000, irq}, 16'h0008);
		wr(tmcc_pkg::ADDR_FLAGS, 8'h08);
		rd(tmcc_pkg::ADDR_FLAGS, b8);
		chk("flag write clear", {8'h00, b8}, 16'h0000);
		chk("irq after clear", {12'h000, irq}, 16'h0000);
		// Falling edge capture, flag cleared by the vector
		wr(tmcc_pkg::ADDR_CTRL_B, 8'h00);
		cap_v = cap_v ^ 16'h5AC3;
		wr16(tmcc_pkg::ADDR_CNT_L, cap_v);
		pins.cap_level(1'b0, 10);
		rd16(tmcc_pkg::ADDR_CAP_L, val);
		chk("capture falling", val, cap_v);
		vec_ack = 4'h8;
		@(posedge clk);
		#2 vec_ack = 4'h0;
		rd(tmcc_pkg::ADDR_FLAGS, b8);
		chk("flag vector clear", {8'h00, b8}, 16'h0000);
		// Filter on: a two clock glitch is ignored, a steady level captures
		wr(tmcc_pkg::ADDR_CTRL_B, 8'hC0);
		wr16(tmcc_pkg::ADDR_CNT_L, ~cap_v);
		pins.cap_level(1'b1, 2);
		pins.cap_level(1'b0, 12);
		rd16(tmcc_pkg::ADDR_CAP_L, val);
		chk("filtered glitch", val, cap_v);
		pins.cap_level(1'b1, 14);
		cap_v = ~cap_v;
		rd16(tmcc_pkg::ADDR_CAP_L, val);
		chk("filtered capture", val, cap_v);
		// Capture register as top: pin edges are ignored
		wr(tmcc_pkg::ADDR_FLAGS, 8'h0F);
		wr(tmcc_pkg::ADDR_CTRL_B, 8'h58);
		wr16(tmcc_pkg::ADDR_CNT_L, 16'h1234);
		pins.cap_level(1'b0, 10);
		pins.cap_level(1'b1, 10);
		rd16(tmcc_pkg::ADDR_CAP_L, val);
		chk("capture disabled", val, cap_v);
		rd(tmcc_pkg::ADDR_FLAGS, b8);
		chk("no capture flag", {8'h00, b8}, 16'h0000);
		wr(tmcc_pkg::ADDR_CTRL_B, 8'h00);
		$display("test capture done");
		// Normal, fast 8-bit and phase correct 8-bit around their tops
		for (int m = 0; m < 3; m++) begin
			wr(tmcc_pkg::ADDR_CTRL_A, ma[m]);
			wr(tmcc_pkg::ADDR_FLAGS, 8'h0F);
			wr16(tmcc_pkg::ADDR_CNT_L, st[m]);
			run(mb[m] | 8'h01, mb[m], 8);
			rd16(tmcc_pkg::ADDR_CNT_L, val);
			chk("mode count", val, ex[m]);
			rd(tmcc_pkg::ADDR_FLAGS, b8);
			chk("overflow flag", {15'h0000, b8[0]}, fl[m]);
		end
		$display("test modes done");
		end_sim();
	end
endmodule : testbench
